// File: src/gir_pkg.sv
package gir_pkg;

    // register byte addresses on the wishbone slave
    localparam logic [7:0] GIR_OFS_CMD     = 8'h00;
    localparam logic [7:0] GIR_OFS_WDL     = 8'h04;
    localparam logic [7:0] GIR_OFS_WDH     = 8'h08;
    localparam logic [7:0] GIR_OFS_STATUS  = 8'h0C;
    localparam logic [7:0] GIR_OFS_RES_LO  = 8'h10;
    localparam logic [7:0] GIR_OFS_RES_HI  = 8'h14;
    localparam logic [7:0] GIR_OFS_VIEW_A  = 8'h18;
    localparam logic [7:0] GIR_OFS_VIEW_B  = 8'h1C;
    localparam logic [7:0] GIR_OFS_VIEW_C  = 8'h20;
    localparam logic [7:0] GIR_OFS_VIEW_D  = 8'h24;
    localparam logic [7:0] GIR_OFS_PENDING = 8'h28;
    localparam logic [7:0] GIR_OFS_MASK    = 8'h2C;

    // command codes and the last setting slot
    localparam logic [3:0] GIR_CMD_SET_GRP  = 4'hC;
    localparam logic [3:0] GIR_CMD_READ_GRP = 4'hD;
    localparam logic [3:0] GIR_SETTING_LAST = 4'h8;
    localparam logic [7:0] GIR_CMD_VIEW_ST  = 8'hD9;
    localparam logic [7:0] GIR_CMD_TR_CLEAR = 8'hE4;
    localparam logic [7:0] GIR_CMD_VIEW_LO  = 8'hE5;
    localparam logic [7:0] GIR_CMD_VIEW_HI  = 8'hE9;

    // setting slots and field positions
    localparam int GIR_SLOT_TEN_LO  = 4;
    localparam int GIR_SLOT_TEN_HI  = 5;
    localparam int GIR_SLOT_TDIR_LO = 6;
    localparam int GIR_SLOT_TDIR_HI = 7;
    localparam int GIR_SLOT_MODE    = 8;
    localparam int GIR_MODE_STROBE_OUTPUT_SET_MODE    = 0;
    localparam int GIR_MODE_STROBE_INPUT_LATCH_MODE    = 2;
    localparam int GIR_MODE_OTSD    = 4;
    localparam int GIR_MODE_INSD    = 5;
    localparam int GIR_IRQ_TIM      = 8;
    localparam int GIR_IRQ_INS      = 9;
    localparam int GIR_IRQ_OTS      = 10;
    localparam int GIR_IRQ_TRN      = 11;
    localparam int GIR_ST_TIM       = 0;
    localparam int GIR_ST_INS       = 1;
    localparam int GIR_ST_OTS       = 2;
    localparam int GIR_EV_TRN       = 3;

    localparam logic [15:0] GIR_SETTING_RESET = 16'h0000;
    localparam logic [3:0]  GIR_MASK_RESET    = 4'h0;

    typedef enum logic [2:0] {
        GIR_VIEW_RT_IO = 3'h0,
        GIR_VIEW_RT_IN = 3'h1,
        GIR_VIEW_LATCH = 3'h2,
        GIR_VIEW_OUT   = 3'h3,
        GIR_VIEW_TRANS = 3'h4
    } gir_view_t;

    localparam gir_view_t GIR_VIEW_RESET = GIR_VIEW_RT_IO;

    typedef logic [8:0][15:0] gir_setting_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } gir_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } gir_wb_rsp_t;

    typedef struct packed {
        logic         ack;
        logic [31:0]  rdat;
        logic [7:0]   wdl;
        logic [7:0]   wdh;
        gir_setting_t setting;
        logic [15:0]  res;
        gir_view_t    view;
        logic [7:0]   status;
        logic [31:0]  flags;
        logic [31:0]  trans_prev;
        logic [3:0]   pending;
        logic [3:0]   mask;
        logic         wb_irq;
        logic         irq_oe;
        logic [1:0]   lat_sync;
        logic [1:0]   set_sync;
        logic         lat_prev;
        logic         set_prev;
        logic         lat_event;
        logic         set_event;
        logic         cmd_pulse;
        logic [7:0]   cmd_code;
    } gir_state_t;

endpackage

// File: src/gir_irq_readback.sv
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps

// Overview of operation
// [RULE1] timer timeout with enable sets flag, irq
// [RULE2] status read releases irq, clears flags
// [RULE3] every continuous timeout raises a new irq
// [RULE4] latch strobe edge with enable sets flag
// [RULE5] latch strobe irq only in latch mode
// [RULE6] latch strobe edge chosen by mode bit
// [RULE7] set strobe edge with enable sets flag
// [RULE8] set strobe irq needs output mode, edge bit
// [RULE9] transition irq on enabled input changes
// [RULE10] transition view read clears that port
// [RULE11] host writes zero to reserved mode bits
// [RULE12] read result low byte, high zero
// [RULE13] readback returns last stored setting values
// [RULE14] readback codes map to setting slots
// [RULE15] view status command reports current view
// [RULE16] view codes zero to four encoded
// [RULE17] view persists until next view command
// [RULE18] transition clear only in transition view
// [RULE19] irq held while any enabled flag set
module gir_irq_readback (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire gir_pkg::gir_wb_req_t wb_req,
    output      gir_pkg::gir_wb_rsp_t wb_rsp,
    output      logic                 wb_irq,
    input  wire logic                 timer_timeout,
    input  wire logic                 input_latch_strobe,
    input  wire logic                 output_set_strobe,
    input  wire logic [31:0]          trans_sample,
    input  wire logic [31:0]          rt_mixed,
    input  wire logic [31:0]          rt_input,
    input  wire logic [31:0]          latched_input,
    input  wire logic [31:0]          output_value,
    output      logic                 interrupt_request_low,
    output      logic                 interrupt_request_low_oe,
    output      gir_pkg::gir_setting_t setting_out,
    output      gir_pkg::gir_view_t   port_view_sel,
    output      logic                 cmd_pulse,
    output      logic [7:0]           cmd_code,
    output      logic                 latch_event,
    output      logic                 set_event
);
    import gir_pkg::*;

    gir_state_t  st;
    gir_state_t  next_st;

    logic        take;
    logic        wr_take;
    logic        rd_take;
    logic [7:0]  wdat;
    logic [15:0] mode;
    logic [31:0] t_en;
    logic [31:0] t_dir;
    logic [31:0] tr_hit;
    logic        lat_edge;
    logic        set_edge;
    logic        lat_fire;
    logic        set_fire;
    logic        tim_fire;
    logic [31:0] view_word;

    // one answer per request; ack high for a cycle stops a double take
    assign take    = wb_req.cyc & wb_req.stb & ~st.ack;
    assign wr_take = take & wb_req.we & wb_req.sel[0];
    assign rd_take = take & ~wb_req.we;
    assign wdat    = wb_req.dat[7:0];
    assign mode    = st.setting[GIR_SLOT_MODE];
    assign t_en    = {st.setting[GIR_SLOT_TEN_HI], st.setting[GIR_SLOT_TEN_LO]};
    assign t_dir   = {st.setting[GIR_SLOT_TDIR_HI], st.setting[GIR_SLOT_TDIR_LO]};

    // direction 0 traps 0->1, 1 traps 1->0
    assign tr_hit = t_en & ((~t_dir & trans_sample & ~st.trans_prev) |
                            (t_dir & ~trans_sample & st.trans_prev));

    // edge taken from the second synchroniser stage only
    assign lat_edge = mode[GIR_MODE_INSD] ? (~st.lat_sync[1] & st.lat_prev)
                                          : (st.lat_sync[1] & ~st.lat_prev); // RULE6
    assign set_edge = mode[GIR_MODE_OTSD] ? (~st.set_sync[1] & st.set_prev)
                                          : (st.set_sync[1] & ~st.set_prev); // RULE8

    assign lat_fire = lat_edge & mode[GIR_MODE_STROBE_INPUT_LATCH_MODE]; // RULE5
    assign set_fire = set_edge & mode[GIR_MODE_STROBE_OUTPUT_SET_MODE]; // RULE8
    assign tim_fire = timer_timeout & mode[GIR_IRQ_TIM]; // RULE3

    always_comb
    begin
        case (st.view)
            GIR_VIEW_RT_IO: view_word = rt_mixed;
            GIR_VIEW_RT_IN: view_word = rt_input;
            GIR_VIEW_LATCH: view_word = latched_input;
            GIR_VIEW_OUT:   view_word = output_value;
            GIR_VIEW_TRANS: view_word = st.flags;
            default:        view_word = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        logic [31:0] clr;
        logic [7:0]  code;
        logic [3:0]  slot;
        clr  = 32'h0000_0000;
        code = wdat;
        slot = wdat[3:0];

        next_st           = st;
        next_st.ack       = take;
        next_st.cmd_pulse = 1'b0;
        next_st.lat_sync  = {st.lat_sync[0], input_latch_strobe};
        next_st.set_sync  = {st.set_sync[0], output_set_strobe};
        next_st.lat_prev  = st.lat_sync[1];
        next_st.set_prev  = st.set_sync[1];
        next_st.lat_event = lat_fire;
        next_st.set_event = set_fire;
        next_st.trans_prev = trans_sample;

        if (rd_take)
        begin
            case (wb_req.adr)
                GIR_OFS_WDL:     next_st.rdat = {24'h00_0000, st.wdl};
                GIR_OFS_WDH:     next_st.rdat = {24'h00_0000, st.wdh};
                GIR_OFS_STATUS:  next_st.rdat = {24'h00_0000, st.status};
                GIR_OFS_RES_LO:  next_st.rdat = {24'h00_0000, st.res[7:0]};
                GIR_OFS_RES_HI:  next_st.rdat = {24'h00_0000, st.res[15:8]};
                GIR_OFS_VIEW_A:  next_st.rdat = {24'h00_0000, view_word[7:0]};
                GIR_OFS_VIEW_B:  next_st.rdat = {24'h00_0000, view_word[15:8]};
                GIR_OFS_VIEW_C:  next_st.rdat = {24'h00_0000, view_word[23:16]};
                GIR_OFS_VIEW_D:  next_st.rdat = {24'h00_0000, view_word[31:24]};
                GIR_OFS_PENDING: next_st.rdat = {28'h000_0000, st.pending};
                GIR_OFS_MASK:    next_st.rdat = {28'h000_0000, st.mask};
                default:         next_st.rdat = 32'h0000_0000;
            endcase
            if (wb_req.adr == GIR_OFS_STATUS)
            begin
                next_st.status = 8'h00; // RULE2
            end
            // reading a port in transition view hands its flags over
            if (st.view == GIR_VIEW_TRANS)
            begin
                case (wb_req.adr)
                    GIR_OFS_VIEW_A: clr[7:0]   = 8'hFF; // RULE10
                    GIR_OFS_VIEW_B: clr[15:8]  = 8'hFF; // RULE10
                    GIR_OFS_VIEW_C: clr[23:16] = 8'hFF; // RULE10
                    GIR_OFS_VIEW_D: clr[31:24] = 8'hFF; // RULE10
                    default:        clr        = 32'h0000_0000;
                endcase
            end
        end
        else if (take)
        begin
            next_st.rdat = 32'h0000_0000;
        end

        if (wr_take)
        begin
            case (wb_req.adr)
                GIR_OFS_WDL:  next_st.wdl  = wdat;
                GIR_OFS_WDH:  next_st.wdh  = wdat;
                GIR_OFS_MASK: next_st.mask = wdat[3:0];
                GIR_OFS_PENDING:
                begin
                    next_st.pending = st.pending & ~wdat[3:0];
                end
                GIR_OFS_CMD:
                begin
                    next_st.cmd_pulse = 1'b1;
                    next_st.cmd_code  = code;
                    if (code[7:4] == GIR_CMD_SET_GRP && slot <= GIR_SETTING_LAST)
                    begin
                        next_st.setting[slot] = {st.wdh, st.wdl};
                    end
                    if (code[7:4] == GIR_CMD_READ_GRP && slot <= GIR_SETTING_LAST)
                    begin
                        next_st.res = st.setting[slot]; // RULE13 RULE14
                    end
                    if (code == GIR_CMD_VIEW_ST)
                    begin
                        next_st.res = {13'h0000, st.view}; // RULE12 RULE15 RULE16
                    end
                    if (code >= GIR_CMD_VIEW_LO && code <= GIR_CMD_VIEW_HI)
                    begin
                        next_st.view = gir_view_t'(code[2:0] - GIR_CMD_VIEW_LO[2:0]); // RULE17
                    end
                    if (code == GIR_CMD_TR_CLEAR && st.view == GIR_VIEW_TRANS)
                    begin
                        clr = 32'hFFFF_FFFF; // RULE18
                    end
                end
                default:
                begin
                    next_st.wdl = st.wdl;
                end
            endcase
        end

        // new events beat a clear in the same cycle
        next_st.flags = (st.flags & ~clr) | tr_hit;
        if (tim_fire)
        begin
            next_st.status[GIR_ST_TIM] = 1'b1; // RULE1
        end
        if (lat_fire && mode[GIR_IRQ_INS])
        begin
            next_st.status[GIR_ST_INS] = 1'b1; // RULE4
        end
        if (set_fire && mode[GIR_IRQ_OTS])
        begin
            next_st.status[GIR_ST_OTS] = 1'b1; // RULE7
        end

        next_st.pending = next_st.pending |
                          {|tr_hit, set_fire, lat_fire, tim_fire};

        // open-drain request: enable asserted means the pin is pulled low
        next_st.irq_oe = (|next_st.status[2:0]) |
                         (mode[GIR_IRQ_TRN] & (|next_st.flags)); // RULE9 RULE19
        next_st.wb_irq = |(next_st.pending & next_st.mask);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st            <= '0;
            st.setting    <= {9{GIR_SETTING_RESET}};
            st.view       <= GIR_VIEW_RESET;
            st.mask       <= GIR_MASK_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign wb_rsp.ack               = st.ack;
    assign wb_rsp.dat               = st.rdat;
    assign wb_irq                   = st.wb_irq;
    // the pin only ever drives low; level is fixed, enable carries the request
    assign interrupt_request_low    = 1'b0;
    assign interrupt_request_low_oe = st.irq_oe;
    assign setting_out              = st.setting;
    assign port_view_sel            = st.view;
    assign cmd_pulse                = st.cmd_pulse;
    assign cmd_code                 = st.cmd_code;
    assign latch_event              = st.lat_event;
    assign set_event                = st.set_event;

    logic cmd_wr;
    logic st_rd;
    assign cmd_wr = wr_take && wb_req.adr == GIR_OFS_CMD;
    assign st_rd  = rd_take && wb_req.adr == GIR_OFS_STATUS;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_timer_sets_flag: assert property ( // RULE1
        timer_timeout && mode[GIR_IRQ_TIM] |=> st.status[0] && st.irq_oe)
        else $error("timer timeout did not raise status and request");

    a_timer_flag_cause: assert property ( // RULE1
        $rose(st.status[0]) |-> $past(timer_timeout && mode[GIR_IRQ_TIM]))
        else $error("timer flag set without an enabled timeout");

    a_trans_flag_cause: assert property ( // RULE9
        $rose(st.flags[0]) |-> $past(t_en[0]))
        else $error("transition flag set on a disabled input");

    a_status_read_clear: assert property ( // RULE2
        st_rd && !tim_fire && !lat_fire && !set_fire |=> st.status == 8'h00)
        else $error("status read did not clear flags");

    a_latch_needs_mode: assert property ( // RULE5
        $rose(st.status[1]) |-> $past(mode[GIR_MODE_STROBE_INPUT_LATCH_MODE] && mode[GIR_IRQ_INS]))
        else $error("latch strobe flag set without latch mode");

    a_set_needs_mode: assert property ( // RULE8
        $rose(st.status[2]) |-> $past(mode[GIR_MODE_STROBE_OUTPUT_SET_MODE] && mode[GIR_IRQ_OTS]))
        else $error("set strobe flag set without output mode");

    a_irq_held_flag: assert property ( // RULE19
        st.status[0] && !st_rd |=> st.irq_oe)
        else $error("request released while a flag stayed set");

    a_view_persists: assert property ( // RULE17
        !cmd_wr |=> $stable(st.view))
        else $error("view changed without a view command");

    a_clear_only_trans: assert property ( // RULE18
        cmd_wr && wdat == GIR_CMD_TR_CLEAR && st.view != GIR_VIEW_TRANS && !rd_take
        |=> st.flags == $past(st.flags | tr_hit))
        else $error("transition clear acted outside transition view");

    a_readback_match: assert property ( // RULE13
        cmd_wr && wdat[7:4] == GIR_CMD_READ_GRP && wdat[3:0] <= GIR_SETTING_LAST
        |=> st.res == $past(st.setting[wdat[3:0]]))
        else $error("readback differs from stored setting");

    a_view_status: assert property ( // RULE15
        cmd_wr && wdat == GIR_CMD_VIEW_ST |=> st.res == {13'h0000, $past(st.view)})
        else $error("view status result wrong");

    a_port_read_clear: assert property ( // RULE10
        rd_take && wb_req.adr == GIR_OFS_VIEW_A && st.view == GIR_VIEW_TRANS
        |=> st.flags[7:0] == $past(tr_hit[7:0]))
        else $error("port read did not clear its transition flags");

    a_ack_single: assert property (
        st.ack |=> !st.ack)
        else $error("ack held longer than one cycle");

    c_timer_irq: cover property (tim_fire ##1 st.irq_oe ##[1:50] st_rd);
    c_trans_release: cover property (
        st.view == GIR_VIEW_TRANS && st.irq_oe ##[1:50] !st.irq_oe);
    c_view_status: cover property (cmd_wr && wdat == GIR_CMD_VIEW_ST);
    c_latch_irq: cover property ($rose(st.status[1]));
    c_set_irq: cover property ($rose(st.status[2]));

endmodule // gir_irq_readback

// File: sim/gir_host_model.sv
`timescale 1ns/100ps

module gir_host_model (
    input  wire logic                 clk,
    output      gir_pkg::gir_wb_req_t wb_req,
    input  wire gir_pkg::gir_wb_rsp_t wb_rsp
);
    import gir_pkg::*;

    initial wb_req = '0;

    // one classic cycle; the trailing idle edge keeps requests two cycles apart
    task automatic access(
        input  logic        we,
        input  logic [7:0]  adr,
        input  logic [31:0] wdat,
        output logic [31:0] rdat
    );
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wdat};
        do @(posedge clk); while (wb_rsp.ack !== 1'b1);
        rdat = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk);
    endtask
endmodule // gir_host_model

// File: sim/gir_irq_and_readback_tb.sv
`timescale 1ns/100ps

`define GIR_CMP(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
            n_mismatch++; \
        end \
    end

module gpio_irq_and_readback_tb;
    import gir_pkg::*;

    logic        clk;
    logic        reset;
    logic        timer_timeout;
    logic        latch_pin;
    logic        set_pin;
    logic [31:0] trans_sample;
    logic [31:0] rd;
    logic [7:0]  b;
    logic [15:0] w;
    gir_wb_req_t wb_req;
    gir_wb_rsp_t wb_rsp;
    logic        wb_irq;
    logic        irq_low;
    logic        irq_oe;
    logic        latch_ev;
    logic        set_ev;
    logic        cmd_pulse;
    logic [7:0]  cmd_code;
    logic [15:0] w_exp;
    gir_setting_t setting_out;
    gir_view_t   view_sel;
    int          n_lat_ev = 0;
    int          n_set_ev = 0;
    int          n_cmd = 0;
    int          n_cmd_exp = 0;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cycles = 0;

    gir_host_model i_gir_host_model (.clk(clk), .wb_req(wb_req), .wb_rsp(wb_rsp));

    gir_irq_readback i_gir_irq_readback (
        .clk(clk), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp), .wb_irq(wb_irq),
        .timer_timeout(timer_timeout), .input_latch_strobe(latch_pin),
        .output_set_strobe(set_pin), .trans_sample(trans_sample),
        .rt_mixed(32'h1111_1111), .rt_input(32'h2222_2222), .latched_input(32'h3333_3333),
        .output_value(32'h4444_4444), .interrupt_request_low(irq_low),
        .interrupt_request_low_oe(irq_oe), .setting_out(setting_out),
        .port_view_sel(view_sel), .cmd_pulse(cmd_pulse), .cmd_code(cmd_code),
        .latch_event(latch_ev), .set_event(set_ev)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        i_gir_host_model.access(1'b1, adr, d, rd);
    endtask

    task automatic rd8(input logic [7:0] adr);
        i_gir_host_model.access(1'b0, adr, 32'h0000_0000, rd);
        b = rd[7:0];
    endtask

    task automatic cmd(input logic [7:0] code);
        n_cmd_exp++;
        wr(GIR_OFS_CMD, {24'h000000, code});
        `GIR_CMP("cmd code", code, cmd_code)
    endtask

    task automatic setting(input logic [3:0] slot, input logic [15:0] v);
        wr(GIR_OFS_WDL, {24'h000000, v[7:0]});
        wr(GIR_OFS_WDH, {24'h000000, v[15:8]});
        cmd({GIR_CMD_SET_GRP, slot});
    endtask

    task automatic readback(input logic [7:0] code);
        cmd(code);
        rd8(GIR_OFS_RES_LO);
        w[7:0] = b;
        rd8(GIR_OFS_RES_HI);
        w[15:8] = b;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic tick();
        @(posedge clk);
        timer_timeout <= 1'b1;
        @(posedge clk);
        timer_timeout <= 1'b0;
        idle(2);
    endtask

    // one strobe pin: rising edge, then falling edge, status read after each
    task automatic strobe_chk(input logic sel_set, input logic [15:0] mode,
                              input logic [7:0] e_rise, input logic [7:0] e_fall);
        int ev0;
        setting(4'h8, mode);
        ev0 = sel_set ? n_set_ev : n_lat_ev;
        rd8(GIR_OFS_STATUS);
        if (sel_set) set_pin <= 1'b1;
        else latch_pin <= 1'b1;
        idle(8);
        `GIR_CMP("strobe irq", (e_rise != 8'h00), irq_oe)
        rd8(GIR_OFS_STATUS);
        `GIR_CMP("status rise", e_rise, b)
        if (sel_set) set_pin <= 1'b0;
        else latch_pin <= 1'b0;
        idle(8);
        rd8(GIR_OFS_STATUS);
        `GIR_CMP("status fall", e_fall, b)
        `GIR_CMP("strobe events", int'(sel_set ? mode[0] : mode[2]), (sel_set ? n_set_ev : n_lat_ev) - ev0)
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        n_lat_ev += int'(latch_ev === 1'b1);
        n_set_ev += int'(set_ev === 1'b1);
        n_cmd += int'(cmd_pulse === 1'b1);
        if (cycles == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial
    begin
        reset = 1'b1;
        timer_timeout = 1'b0;
        latch_pin = 1'b0;
        set_pin = 1'b0;
        trans_sample = 32'h0000_0000;
        idle(6);
        reset <= 1'b0;
        rd8(GIR_OFS_STATUS);
        `GIR_CMP("status at reset", 8'h00, b)
        for (int n = 0; n < 8; n++) setting(4'(n), 16'h1234 ^ (16'(n) * 16'h1111));
        setting(4'h8, 16'h0F05);
        for (int n = 0; n < 9; n++)
        begin
            w_exp = (n == 8) ? 16'h0F05 : 16'h1234 ^ (16'(n) * 16'h1111);
            readback({GIR_CMD_READ_GRP, 4'(n)});
            `GIR_CMP("readback", w_exp, w)
            `GIR_CMP("setting out", w_exp, setting_out[n])
        end
        for (int v = 0; v < 5; v++)
        begin
            cmd(GIR_CMD_VIEW_LO + 8'(v));
            `GIR_CMP("view sel", 3'(v), view_sel)
            rd8(GIR_OFS_VIEW_A);
            `GIR_CMP("view a", (v < 4) ? 8'(8'h11 * (v + 1)) : 8'h00, b)
            readback(GIR_CMD_VIEW_ST);
            `GIR_CMP("view status", 16'(v), w)
        end
        wr(GIR_OFS_MASK, 32'h0000_000F);
        for (int k = 0; k < 2; k++)
        begin
            tick();
            `GIR_CMP("timer irq", 1'b1, irq_oe)
            `GIR_CMP("wb irq", 1'b1, wb_irq)
            rd8(GIR_OFS_STATUS);
            `GIR_CMP("timer status", 8'h01, b)
            `GIR_CMP("irq released", 1'b0, irq_oe)
            rd8(GIR_OFS_STATUS);
            `GIR_CMP("status cleared", 8'h00, b)
        end
        wr(GIR_OFS_PENDING, 32'h0000_000F);
        wr(GIR_OFS_MASK, 32'h0000_0000);
        tick();
        `GIR_CMP("masked wb irq", 1'b0, wb_irq)
        rd8(GIR_OFS_PENDING);
        `GIR_CMP("pending", 8'h01, b)
        wr(GIR_OFS_PENDING, 32'h0000_0001);
        rd8(GIR_OFS_PENDING);
        `GIR_CMP("pending cleared", 8'h00, b)
        rd8(GIR_OFS_STATUS);
        setting(4'h8, 16'h0E05);
        tick();
        `GIR_CMP("timer disabled", 1'b0, irq_oe)
        rd8(GIR_OFS_STATUS);
        `GIR_CMP("timer disabled st", 8'h00, b)
        strobe_chk(1'b0, 16'h0F04, 8'h02, 8'h00);
        strobe_chk(1'b0, 16'h0F24, 8'h00, 8'h02);
        strobe_chk(1'b0, 16'h0F00, 8'h00, 8'h00);
        strobe_chk(1'b1, 16'h0F01, 8'h04, 8'h00);
        strobe_chk(1'b1, 16'h0F11, 8'h00, 8'h04);
        strobe_chk(1'b1, 16'h0F00, 8'h00, 8'h00);
        setting(4'h4, 16'h0001);
        setting(4'h6, 16'h0000);
        setting(4'h8, 16'h0800);
        cmd(GIR_CMD_VIEW_HI);
        cmd(GIR_CMD_TR_CLEAR);
        trans_sample <= 32'h0000_0002;
        idle(4);
        `GIR_CMP("disabled input", 1'b0, irq_oe)
        trans_sample <= 32'h0000_0003;
        idle(4);
        `GIR_CMP("transition irq", 1'b1, irq_oe)
        rd8(GIR_OFS_VIEW_A);
        `GIR_CMP("view a flags", 8'h01, b)
        `GIR_CMP("transition released", 1'b0, irq_oe)
        setting(4'h6, 16'h0001);
        cmd(GIR_CMD_TR_CLEAR);
        trans_sample <= 32'h0000_0002;
        idle(4);
        `GIR_CMP("falling transition", 1'b1, irq_oe)
        cmd(GIR_CMD_VIEW_LO);
        cmd(GIR_CMD_TR_CLEAR);
        `GIR_CMP("clear outside view", 1'b1, irq_oe)
        cmd(GIR_CMD_VIEW_HI);
        cmd(GIR_CMD_TR_CLEAR);
        `GIR_CMP("clear in view", 1'b0, irq_oe)
        reset <= 1'b1;
        idle(2);
        reset <= 1'b0;
        readback(GIR_CMD_VIEW_ST);
        `GIR_CMP("view after reset", 16'h0000, w)
        `GIR_CMP("setting after reset", 16'h0000, setting_out[8])
        rd8(8'h30);
        `GIR_CMP("unmapped read", 8'h00, b)
        `GIR_CMP("request level", 1'b0, irq_low)
        `GIR_CMP("cmd pulses", n_cmd_exp, n_cmd)
        wrap_up();
    end
endmodule // gpio_irq_and_readback_tb
